/* icpc_regs.sv */
`timescale 1ns/1ps
`include "icpc_params.svh"

// Notes on behaviour
// R1: preview height is vertical field plus one, 480 max
// R2: preview width is horizontal field plus one, 640 max
// R3: decimation factor 16..255; 16 or less bypasses
// R4: descriptor write starts queue; read gives current
// R5: descriptor address forced to word alignment
// R6: codec base address drives codec buffer start
// R7: four 8-bit yuv-to-rgb coefficients, 1/128 steps
// R8: fifth 9-bit coefficient, 1/128 steps
// R9: luminance offset bit selects offset 128
// R10: chroma offset bits select offset 16
// R11: first rgb-to-yuv set scaling per byte
// R12: red offset bit selects offset 16
// R13: second rgb-to-yuv set scaling per byte
// R14: green offset bit selects offset 128
// R15: third rgb-to-yuv set scaling per byte
// R16: blue offset bit selects offset 128
// R17: registers read back, reserved bits zero
module icpc_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic                 clk_sys_i,        // system clock
  input  wire logic                 rst_n_i,          // sync reset, active low
  input  wire logic                 psel_i,           // apb select
  input  wire logic                 penable_i,        // apb enable
  input  wire logic                 pwrite_i,         // apb direction
  input  wire logic [ADDR_W-1:0]    paddr_i,          // apb byte address
  input  wire logic [31:0]          pwdata_i,         // apb write data
  input  wire logic [3:0]           pstrb_i,          // apb byte strobes
  output logic      [31:0]          prdata_o,         // apb read data
  output logic                      pready_o,         // apb ready
  output logic                      pslverr_o,        // apb error
  input  wire logic [31:0]          cur_desc_ptr_i,   // descriptor now in use
  input  wire logic                 cur_desc_vld_i,   // pointer update strobe
  output icpc_pkg::icpc_preview_s   preview_o,        // preview geometry
  output logic      [31:0]          desc_queue_o,     // descriptor queue start
  output logic                      desc_restart_o,   // queue restart pulse
  output logic      [31:0]          codec_base_o,     // codec buffer base
  output icpc_pkg::icpc_y2r_s       y2r_o,            // yuv-to-rgb setup
  output icpc_pkg::icpc_r2y_s       r2y_o             // rgb-to-yuv setup
);
  import icpc_pkg::*;

  // ----------------------------------------------------------------
  // register tables
  // ----------------------------------------------------------------
  // entries in word-index order
  localparam logic [31:0] RST_VAL [`ICPC_NUM_REGS] = '{
    `ICPC_RST_PSIZE,
    `ICPC_RST_PDEC,
    `ICPC_RST_PDESC,
    `ICPC_RST_CBASE,
    `ICPC_RST_Y2R_A,
    `ICPC_RST_Y2R_B,
    `ICPC_RST_R2Y_A,
    `ICPC_RST_R2Y_B,
    `ICPC_RST_R2Y_C
  };

  localparam logic [31:0] BIT_MSK [`ICPC_NUM_REGS] = '{
    `ICPC_MSK_PSIZE,
    `ICPC_MSK_PDEC,
    `ICPC_MSK_PDESC,
    `ICPC_MSK_CBASE,
    `ICPC_MSK_Y2R_A,
    `ICPC_MSK_Y2R_B,
    `ICPC_MSK_R2Y,
    `ICPC_MSK_R2Y,
    `ICPC_MSK_R2Y
  };

  localparam logic [3:0] NUM_REGS = 4'(`ICPC_NUM_REGS);

  logic [31:0] regs [`ICPC_NUM_REGS];
  logic [31:0] cur_ptr;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic [3:0]  idx;
  logic        mapped;
  logic        access;
  logic        commit;
  logic        wr_commit;
  logic [31:0] strb_mask;
  logic [`ICPC_NUM_REGS-1:0] wr_sel;

  // index field above the byte lane bits
  assign idx = 4'(paddr_i[ADDR_W-1:2]);

  assign mapped = (idx < NUM_REGS) && (paddr_i[ADDR_W-1:2] < NUM_REGS);

  // access phase waiting for our ready
  assign access = psel_i && penable_i && !pready_o;

  // the edge where the master samples ready high
  assign commit = psel_i && penable_i && pready_o;

  // a refused (unmapped) write never lands
  assign wr_commit = commit && pwrite_i && !pslverr_o;

  // each strobe bit opens one byte lane
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_lane
      assign strb_mask[gb*8 +: 8] = {8{pstrb_i[gb]}};
    end
  endgenerate

  // ----------------------------------------------------------------
  // handshake: one wait state, ready and error from flops
  // ----------------------------------------------------------------
  // ready rises on the first access edge and lasts one cycle, so
  // every access phase is exactly two cycles long
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
    end else if (access) begin
      pready_o <= 1'b1;
    end else begin
      pready_o <= 1'b0;
    end
  end

  // error only for an index past the table
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pslverr_o <= 1'b0;
    end else if (access) begin
      pslverr_o <= !mapped; // R17
    end else begin
      pslverr_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [31:0] rd_val;
  logic [31:0] rd_term [`ICPC_NUM_REGS];

  // and-or mux: an unmapped index that aliases a real entry after
  // truncation must still read as zero
  always_comb begin
    rd_val = 32'h00000000;
    for (int k = 0; k < `ICPC_NUM_REGS; k++) begin
      rd_val = rd_val | rd_term[k]; // R17
    end
    if (mapped && idx == `ICPC_IDX_PDESC) begin
      rd_val = cur_ptr & `ICPC_MSK_PDESC; // R4
    end
  end

  // ----------------------------------------------------------------
  // read data register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h00000000;
    end else if (access && !pwrite_i) begin
      prdata_o <= rd_val;
    end else if (commit) begin
      // drop stale data once the transfer ends
      prdata_o <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // register storage, one writer per entry
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `ICPC_NUM_REGS; gi++) begin : g_reg
      // per entry: write select, read term, storage
      assign wr_sel[gi]  = wr_commit && (idx == 4'(gi));
      assign rd_term[gi] = (mapped && idx == 4'(gi)) ? (regs[gi] & BIT_MSK[gi]) : 32'h00000000; // R17

      always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          regs[gi] <= RST_VAL[gi];
        end else if (wr_sel[gi]) begin
          // unimplemented bits stay zero, low descriptor bits too
          regs[gi] <= ((regs[gi] & ~strb_mask) | (pwdata_i & strb_mask))
                      & BIT_MSK[gi]; // R5 R17
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // current descriptor pointer
  // ----------------------------------------------------------------
  logic desc_wr;

  assign desc_wr = wr_commit && (idx == `ICPC_IDX_PDESC);

  // a software write restarts the queue, so it wins over a
  // pointer update from the descriptor walker in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cur_ptr <= `ICPC_RST_PDESC;
    end else if (desc_wr) begin
      cur_ptr <= ((regs[`ICPC_IDX_PDESC] & ~strb_mask) | (pwdata_i & strb_mask))
                 & `ICPC_MSK_PDESC; // R4 R5
    end else if (cur_desc_vld_i) begin
      cur_ptr <= cur_desc_ptr_i & `ICPC_MSK_PDESC; // R5
    end
  end

  // ----------------------------------------------------------------
  // queue start and restart strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      desc_restart_o <= 1'b0;
    end else begin
      desc_restart_o <= desc_wr; // R4
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      desc_queue_o <= `ICPC_RST_PDESC;
    end else begin
      desc_queue_o <= regs[`ICPC_IDX_PDESC]; // R4 R5
    end
  end

  // ----------------------------------------------------------------
  // preview geometry and decimation
  // ----------------------------------------------------------------
  logic [9:0]  vsize;
  logic [9:0]  hsize;
  logic [10:0] height_raw;
  logic [10:0] width_raw;
  logic [7:0]  dec_raw;
  logic        height_over;
  logic        width_over;
  logic        dec_bypass;
  icpc_preview_s next_preview;

  assign vsize      = regs[`ICPC_IDX_PSIZE][`ICPC_VSIZE_LSB +: 10];
  assign hsize      = regs[`ICPC_IDX_PSIZE][`ICPC_HSIZE_LSB +: 10];
  assign height_raw = {1'b0, vsize} + 11'd1;
  assign width_raw  = {1'b0, hsize} + 11'd1;
  assign dec_raw    = regs[`ICPC_IDX_PDEC][7:0];

  // sizes past the path limit saturate rather than wrap; the
  // register itself keeps what software wrote
  assign height_over = (height_raw > `ICPC_MAX_HEIGHT); // R1
  assign width_over  = (width_raw > `ICPC_MAX_WIDTH); // R2

  // sixteen and below pass every frame undecimated
  assign dec_bypass  = (dec_raw <= `ICPC_DEC_NONE); // R3

  always_comb begin
    next_preview        = '0;
    next_preview.height = height_over ? `ICPC_MAX_HEIGHT : height_raw; // R1
    next_preview.width  = width_over ? `ICPC_MAX_WIDTH : width_raw; // R2
    next_preview.bypass = dec_bypass; // R3
    next_preview.factor = dec_bypass ? `ICPC_DEC_NONE : dec_raw; // R3
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      preview_o <= '0;
    end else begin
      preview_o <= next_preview;
    end
  end

  // ----------------------------------------------------------------
  // codec buffer base
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      codec_base_o <= `ICPC_RST_CBASE;
    end else begin
      codec_base_o <= regs[`ICPC_IDX_CBASE]; // R6
    end
  end

  // ----------------------------------------------------------------
  // yuv-to-rgb converter setup
  // ----------------------------------------------------------------
  // coefficients are unsigned fixed point; the consumer applies
  // the step, so the raw codes are passed on unchanged
  icpc_y2r_s   next_y2r;
  logic [31:0] y2r_a;
  logic [31:0] y2r_b;
  logic        y_off_en;
  logic        cr_off_en;
  logic        cb_off_en;

  assign y2r_a = regs[`ICPC_IDX_Y2R_A];
  assign y2r_b = regs[`ICPC_IDX_Y2R_B];

  // offset amounts are fixed, software only chooses their use
  assign y_off_en  = y2r_b[`ICPC_Y2R_YOFF_BIT]; // R9
  assign cr_off_en = y2r_b[`ICPC_Y2R_CROFF_BIT]; // R10
  assign cb_off_en = y2r_b[`ICPC_Y2R_CBOFF_BIT]; // R10

  always_comb begin
    next_y2r        = '0;
    next_y2r.c0     = y2r_a[7:0];   // R7
    next_y2r.c1     = y2r_a[15:8];  // R7
    next_y2r.c2     = y2r_a[23:16]; // R7
    next_y2r.c3     = y2r_a[31:24]; // R7
    next_y2r.c4     = y2r_b[`ICPC_Y2R_C4_LSB +: 9]; // R8
    next_y2r.y_off  = y_off_en ? `ICPC_OFF_128 : 8'h00; // R9
    next_y2r.cr_off = cr_off_en ? `ICPC_OFF_16 : 8'h00; // R10
    next_y2r.cb_off = cb_off_en ? `ICPC_OFF_16 : 8'h00; // R10
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      y2r_o <= '0;
    end else begin
      y2r_o <= next_y2r;
    end
  end

  // ----------------------------------------------------------------
  // rgb-to-yuv converter setup
  // ----------------------------------------------------------------
  // step per byte differs by set: a = 1/256,1/128,1/512;
  // b = 1/128,1/256,1/512; c = 1/512,1/256,1/128
  icpc_r2y_s   next_r2y;
  logic [31:0] r2y_a;
  logic [31:0] r2y_b;
  logic [31:0] r2y_c;
  logic        r_off_en;
  logic        g_off_en;
  logic        b_off_en;

  assign r2y_a = regs[`ICPC_IDX_R2Y_A];
  assign r2y_b = regs[`ICPC_IDX_R2Y_B];
  assign r2y_c = regs[`ICPC_IDX_R2Y_C];

  assign r_off_en = r2y_a[`ICPC_R2Y_OFF_BIT]; // R12
  assign g_off_en = r2y_b[`ICPC_R2Y_OFF_BIT]; // R14
  assign b_off_en = r2y_c[`ICPC_R2Y_OFF_BIT]; // R16

  always_comb begin
    next_r2y       = '0;
    next_r2y.c0    = r2y_a[7:0];   // R11
    next_r2y.c1    = r2y_a[15:8];  // R11
    next_r2y.c2    = r2y_a[23:16]; // R11
    next_r2y.c3    = r2y_b[7:0];   // R13
    next_r2y.c4    = r2y_b[15:8];  // R13
    next_r2y.c5    = r2y_b[23:16]; // R13
    next_r2y.c6    = r2y_c[7:0];   // R15
    next_r2y.c7    = r2y_c[15:8];  // R15
    next_r2y.c8    = r2y_c[23:16]; // R15
    next_r2y.r_off = r_off_en ? `ICPC_OFF_16 : 8'h00; // R12
    next_r2y.g_off = g_off_en ? `ICPC_OFF_128 : 8'h00; // R14
    next_r2y.b_off = b_off_en ? `ICPC_OFF_128 : 8'h00; // R16
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      r2y_o <= '0;
    end else begin
      r2y_o <= next_r2y;
    end
  end

endmodule : icpc_regs

/* icpc_params.svh */
`ifndef ICPC_PARAMS_SVH
`define ICPC_PARAMS_SVH

// word index of each register (byte address = index * 4)
`define ICPC_IDX_PSIZE      4'd0
`define ICPC_IDX_PDEC       4'd1
`define ICPC_IDX_PDESC      4'd2
`define ICPC_IDX_CBASE      4'd3
`define ICPC_IDX_Y2R_A      4'd4
`define ICPC_IDX_Y2R_B      4'd5
`define ICPC_IDX_R2Y_A      4'd6
`define ICPC_IDX_R2Y_B      4'd7
`define ICPC_IDX_R2Y_C      4'd8
`define ICPC_NUM_REGS       9

// reset values
`define ICPC_RST_PSIZE      32'h00000000
`define ICPC_RST_PDEC       32'h00000010
`define ICPC_RST_PDESC      32'h00000000
`define ICPC_RST_CBASE      32'h00000000
`define ICPC_RST_Y2R_A      32'h6832CC95
`define ICPC_RST_Y2R_B      32'h00007102
`define ICPC_RST_R2Y_A      32'h01324145
`define ICPC_RST_R2Y_B      32'h01245E38
`define ICPC_RST_R2Y_C      32'h01384A4B

// implemented bits; all others read as zero
`define ICPC_MSK_PSIZE      32'h03FF03FF
`define ICPC_MSK_PDEC       32'h000000FF
`define ICPC_MSK_PDESC      32'hFFFFFFFC
`define ICPC_MSK_CBASE      32'hFFFFFFFF
`define ICPC_MSK_Y2R_A      32'hFFFFFFFF
`define ICPC_MSK_Y2R_B      32'h000071FF
`define ICPC_MSK_R2Y        32'h01FFFFFF

// field positions
`define ICPC_VSIZE_LSB      0
`define ICPC_HSIZE_LSB      16
`define ICPC_Y2R_C4_LSB     0
`define ICPC_Y2R_YOFF_BIT   12
`define ICPC_Y2R_CROFF_BIT  13
`define ICPC_Y2R_CBOFF_BIT  14
`define ICPC_R2Y_OFF_BIT    24

// limits and offset amounts
`define ICPC_MAX_HEIGHT     11'd480
`define ICPC_MAX_WIDTH      11'd640
`define ICPC_DEC_NONE       8'h10
`define ICPC_OFF_128        8'h80
`define ICPC_OFF_16         8'h10

`endif

/* icpc_pkg.sv */
package icpc_pkg;

  typedef struct packed {
    logic [7:0] c0;
    logic [7:0] c1;
    logic [7:0] c2;
    logic [7:0] c3;
    logic [8:0] c4;
    logic [7:0] y_off;
    logic [7:0] cr_off;
    logic [7:0] cb_off;
  } icpc_y2r_s;

  typedef struct packed {
    logic [7:0] c0;
    logic [7:0] c1;
    logic [7:0] c2;
    logic [7:0] c3;
    logic [7:0] c4;
    logic [7:0] c5;
    logic [7:0] c6;
    logic [7:0] c7;
    logic [7:0] c8;
    logic [7:0] r_off;
    logic [7:0] g_off;
    logic [7:0] b_off;
  } icpc_r2y_s;

  typedef struct packed {
    logic [10:0] height;
    logic [10:0] width;
    logic [7:0]  factor;
    logic        bypass;
  } icpc_preview_s;

endpackage : icpc_pkg

/* icpc_walker_model.sv */
`timescale 1ns/1ps
module icpc_walker_model (
  input  wire logic        clk_sys_i, // clock
  output logic      [31:0] ptr_o,     // current pointer
  output logic             vld_o      // load strobe
);
  initial begin
    ptr_o = 32'h0;
    vld_o = 1'b0;
  end

  // pointer is only qualified by the strobe, so it is scrambled outside it
  task automatic hop(input logic [31:0] p);
    @(posedge clk_sys_i);
    ptr_o <= p;
    vld_o <= 1'b1;
    @(posedge clk_sys_i);
    ptr_o <= ~p;
    vld_o <= 1'b0;
  endtask : hop
endmodule : icpc_walker_model

/* icpc_regs_monitor.sv */
`timescale 1ns/1ps
module icpc_regs_monitor #(
  parameter int ADDR_W = 8
) (
  input wire logic                   clk_sys_i,      // clock
  input wire logic                   rst_n_i,        // reset
  input wire logic                   psel_i,         // select
  input wire logic                   penable_i,      // enable
  input wire logic                   pwrite_i,       // direction
  input wire logic [ADDR_W-1:0]      paddr_i,        // address
  input wire logic [31:0]            prdata_o,       // read data
  input wire logic                   pready_o,       // ready
  input wire logic                   pslverr_o,      // error
  input wire icpc_pkg::icpc_preview_s preview_o,     // geometry
  input wire logic [31:0]            desc_queue_o,   // queue start
  input wire logic                   desc_restart_o, // restart
  input wire icpc_pkg::icpc_y2r_s    y2r_o,          // yuv-to-rgb
  input wire icpc_pkg::icpc_r2y_s    r2y_o           // rgb-to-yuv
);
  import icpc_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  chk_ready_late: assert property (psel_i && penable_i && !pready_o |=> pready_o) else $error("ready late");
  chk_ready_one: assert property (pready_o |=> !pready_o) else $error("ready held");
  chk_err_unmapped: assert property (pready_o |-> pslverr_o == (paddr_i[ADDR_W-1:2] > 8)) else $error("bad err");
  chk_rdata_idle: assert property (!pready_o || pwrite_i |-> prdata_o == 32'h0) else $error("rdata not zero");
  chk_height_max: assert property (preview_o.height <= 11'd480) else $error("height over");
  chk_width_max: assert property (preview_o.width <= 11'd640) else $error("width over");
  chk_bypass_factor: assert property (preview_o.bypass |-> preview_o.factor == 8'h10) else $error("bypass");
  chk_desc_aligned: assert property (desc_queue_o[1:0] == 2'b00) else $error("unaligned");
  chk_desc_restart: assert property (psel_i && penable_i && pready_o && pwrite_i && paddr_i[ADDR_W-1:2] == 2
    |=> desc_restart_o ##1 !desc_restart_o) else $error("restart pulse");
  chk_y2r_offsets: assert property ((y2r_o.y_off & 8'h7F) == 0 && (y2r_o.cr_off & 8'hEF) == 0
    && (y2r_o.cb_off & 8'hEF) == 0) else $error("y2r offset");
  chk_r2y_offsets: assert property ((r2y_o.r_off & 8'hEF) == 0 && (r2y_o.g_off & 8'h7F) == 0
    && (r2y_o.b_off & 8'h7F) == 0) else $error("r2y offset");
endmodule : icpc_regs_monitor

/* icpc_regs_bench.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module icpc_regs_bench;
  import icpc_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} icpc_row_s;
  logic          clk_sys_i = 0, rst_n_i = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]    paddr = 8'h0;
  logic [3:0]    pstrb = 4'h0;
  logic [31:0]   pwdata = 32'h0, prdata, desc_q, cbase, ptr, rv;
  logic          pready, pslverr, restart, vld, ev;
  icpc_preview_s pv;
  icpc_y2r_s     y2r;
  icpc_r2y_s     r2y;
  int            fail_count = 0, n_tests = 0, cyc = 0;
  icpc_row_s     rows[9] = '{'{8'h00, 32'hFFFFFFFF, 32'h03FF03FF}, '{8'h04, 32'hFFFFFFFF, 32'h000000FF},
    '{8'h08, 32'hFFFFFFFF, 32'hFFFFFFFC}, '{8'h0C, 32'hA5A5A5A5, 32'hA5A5A5A5}, '{8'h10, 32'h12345678, 32'h12345678},
    '{8'h14, 32'hFFFFFFFF, 32'h000071FF}, '{8'h18, 32'hFFFFFFFF, 32'h01FFFFFF}, '{8'h1C, 32'hFFFFFFFF, 32'h01FFFFFF},
    '{8'h20, 32'hFFFFFFFF, 32'h01FFFFFF}};
  logic [31:0]   rst_v[9] = '{32'h0, 32'h10, 32'h0, 32'h0, 32'h6832CC95, 32'h7102, 32'h01324145, 32'h01245E38,
    32'h01384A4B};
  logic [7:0]    dv[3] = '{8'h11, 8'h10, 8'h05};

  always #5 clk_sys_i = ~clk_sys_i;

  icpc_regs dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .cur_desc_ptr_i(ptr), .cur_desc_vld_i(vld), .preview_o(pv),
    .desc_queue_o(desc_q), .desc_restart_o(restart), .codec_base_o(cbase), .y2r_o(y2r), .r2y_o(r2y));
  icpc_walker_model walker_u (.clk_sys_i(clk_sys_i), .ptr_o(ptr), .vld_o(vld));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  // request held until ready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    @(posedge clk_sys_i);
    while (pready !== 1'b1) @(posedge clk_sys_i);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    `CHK("rdata", e, rv)
  endtask : rd

  // derived outputs lag the register by one clock
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
    repeat (2) @(posedge clk_sys_i);
  endtask : wr

  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ----------
  // stimulus
  // ----------
  initial begin
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 9; i++) rd(8'(i * 4), rst_v[i]);
    `CHK("y_off", 8'h80, y2r.y_off)
    `CHK("cr_off", 8'h10, y2r.cr_off)
    `CHK("c4", 9'h102, y2r.c4)
    `CHK("bypass", 1'b1, pv.bypass)
    `CHK("r_off", 8'h10, r2y.r_off)
    `CHK("g_off", 8'h80, r2y.g_off)
    `CHK("b_off", 8'h80, r2y.b_off)
    `CHK("y2r_a", 32'h6832CC95, {y2r.c3, y2r.c2, y2r.c1, y2r.c0})
    `CHK("r2y_a", 24'h324145, {r2y.c2, r2y.c1, r2y.c0})
    `CHK("r2y_b", 24'h245E38, {r2y.c5, r2y.c4, r2y.c3})
    `CHK("r2y_c", 24'h384A4B, {r2y.c8, r2y.c7, r2y.c6})
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].e);
    end
    `CHK("height", 11'd480, pv.height)
    `CHK("width", 11'd640, pv.width)
    `CHK("codec", 32'hA5A5A5A5, cbase)
    `CHK("y2r_c3", 8'h12, y2r.c3)
    `CHK("y2r_c4", 9'h1FF, y2r.c4)
    $display("row test done");
    wr(8'h00, 32'h027F01DF);
    `CHK("height", 11'd480, pv.height)
    `CHK("width", 11'd640, pv.width)
    wr(8'h00, 32'h00050009);
    `CHK("height", 11'd10, pv.height)
    `CHK("width", 11'd6, pv.width)
    foreach (dv[i]) begin
      wr(8'h04, {24'h0, dv[i]});
      `CHK("factor", dv[i] > 8'h10 ? dv[i] : 8'h10, pv.factor)
      `CHK("bypass", dv[i] <= 8'h10, pv.bypass)
    end
    wr(8'h08, 32'h12345677);
    `CHK("queue", 32'h12345674, desc_q)
    rd(8'h08, 32'h12345674);
    walker_u.hop(32'hABCDEF03);
    rd(8'h08, 32'hABCDEF00);
    `CHK("queue", 32'h12345674, desc_q)
    wr(8'h14, 32'h00001000);
    `CHK("y_off", 8'h80, y2r.y_off)
    `CHK("cb_off", 8'h00, y2r.cb_off)
    `CHK("cr_off", 8'h00, y2r.cr_off)
    wr(8'h14, 32'h00006000);
    `CHK("y_off", 8'h00, y2r.y_off)
    `CHK("cb_off", 8'h10, y2r.cb_off)
    for (int a = 8'h18; a <= 8'h20; a += 4) wr(8'(a), 32'h00FFFFFF);
    `CHK("offs", 24'h0, {r2y.r_off, r2y.g_off, r2y.b_off})
    `CHK("r2y_c8", 8'hFF, r2y.c8)
    apb(1'b1, 8'h0C, 32'h11223344, 4'b0001);
    rd(8'h0C, 32'hA5A5A544);
    apb(1'b1, 8'h24, 32'hFFFFFFFF, 4'hF);
    `CHK("err", 1'b1, ev)
    rd(8'h24, 32'h0);
    `CHK("err", 1'b1, ev)
    rd(8'h48, 32'h0);
    `CHK("err", 1'b1, ev)
    $display("edge test done");
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd(8'h10, 32'h6832CC95);
    rd(8'h08, 32'h0);
    `CHK("y2r_c3", 8'h68, y2r.c3)
    $display("second reset test done");
    tally_and_finish();
  end
endmodule : icpc_regs_bench

bind icpc_regs icpc_regs_monitor #(.ADDR_W(ADDR_W)) mon_u (.*);
